/* File: hdl/master_page_power_sysref_control.v */
// master page register slice: power-down masks, global sleep and reference timing controls
`timescale 1ns/1ps
`include "master_page_consts.vh"
module master_page_power_sysref_control (
   input  wire       core_clk,
   input  wire       reset,
   input  wire       wr_en,
   input  wire       rd_en,
   input  wire [7:0] addr,
   input  wire [7:0] wr_data,
   output reg  [7:0] rd_data_q,
   output reg        rd_valid_q,
   input  wire       sleep_pin,
   input  wire       sysref_in,
   input  wire [3:0] mask1_core_off,
   input  wire [1:0] mask1_chan_a_buffer_off,
   input  wire [1:0] mask1_chan_b_buffer_off,
   input  wire [3:0] mask2_core_off,
   output reg  [3:0] chan_a_core_off_q,
   output reg  [3:0] chan_b_core_off_q,
   output reg        chan_a_buffer_off_q,
   output reg        chan_b_buffer_off_q,
   output reg        whole_device_sleep_q,
   output reg        input_bias_high_ohm_q,
   output reg        sysref_high_common_mode_q,
   output reg        sysref_out_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // stored fields; mask one and the core fields of mask two live elsewhere

   reg [1:0] chan_a_buffer_code_q;
   reg [1:0] chan_b_buffer_off_r_q;
   reg       sleep_pin_ignore_q;
   reg       sleep_pattern_select_q;
   reg       whole_sleep_bit_q;
   reg       input_bias_bit_q;
   reg       sysref_ignore_q;
   reg       sysref_hcm_bit_q;
   reg       sysref_manual_level_q;
   reg       sysref_manual_on_q;
   reg       sleep_pattern_enable_q;

   wire      pin_level;
   wire      sysref_level;

   // both domain-crossing inputs come from pins
   pin_sync3 u_sleep_sync (
      .core_clk    (core_clk),
      .reset       (reset),
      .pin_in      (sleep_pin),
      .pin_level_q (pin_level)
   );

   pin_sync3 u_sysref_sync (
      .core_clk    (core_clk),
      .reset       (reset),
      .pin_in      (sysref_in),
      .pin_level_q (sysref_level)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // buffer code decode; reserved codes are treated as "off" to fail safe

   function buf_off;
      input [1:0] code;
      begin
         buf_off = (code != `BUF_ALL_ON);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // register writes

   always @(posedge core_clk) begin
      if (reset) begin
         chan_a_buffer_code_q   <= 2'h0;
         chan_b_buffer_off_r_q  <= 2'h0;
         sleep_pin_ignore_q     <= 1'b0;
         sleep_pattern_select_q <= 1'b0;
         whole_sleep_bit_q      <= 1'b0;
         input_bias_bit_q       <= 1'b0;
         sysref_ignore_q        <= 1'b0;
         sysref_hcm_bit_q       <= 1'b0;
         sysref_manual_level_q  <= 1'b0;
         sysref_manual_on_q     <= 1'b0;
         sleep_pattern_enable_q <= 1'b0;
      end else if (wr_en) begin
         case (addr)
            `OFS_MASK2_BUF: begin
               chan_b_buffer_off_r_q <= wr_data[`BIT_CHB_BUF_HI:`BIT_CHB_BUF_LO];
               chan_a_buffer_code_q  <= wr_data[`BIT_CHA_BUF_HI:`BIT_CHA_BUF_LO];
            end
            `OFS_PDN_CTRL: begin
               sleep_pin_ignore_q     <= wr_data[`BIT_PIN_IGNORE];
               sleep_pattern_select_q <= wr_data[`BIT_PATTERN_SEL];
               // global sleep only programmable once override is already set
               if (sleep_pin_ignore_q) begin
                  whole_sleep_bit_q <= wr_data[`BIT_WHOLE_SLEEP];
               end
            end
            `OFS_INPUT_COUPLING: begin
               input_bias_bit_q <= wr_data[`BIT_INPUT_BIAS];
            end
            `OFS_SYSREF_CTRL: begin
               sysref_ignore_q       <= wr_data[`BIT_SYSREF_IGNORE];
               sysref_hcm_bit_q      <= wr_data[`BIT_SYSREF_HCM];
               sysref_manual_level_q <= wr_data[`BIT_SYSREF_LEVEL];
            end
            `OFS_SYSREF_MANUAL: begin
               sysref_manual_on_q <= wr_data[`BIT_SYSREF_MANUAL];
            end
            `OFS_MASK_ENABLE: begin
               sleep_pattern_enable_q <= wr_data[`BIT_PATTERN_ENABLE];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read back; reserved bits and unmapped offsets read zero

   reg [7:0] rd_mux;

   always @* begin
      rd_mux = `RESET_VALUE;
      case (addr)
         `OFS_MASK2_BUF: begin
            rd_mux[`BIT_CHB_BUF_HI:`BIT_CHB_BUF_LO] = chan_b_buffer_off_r_q;
            rd_mux[`BIT_CHA_BUF_HI:`BIT_CHA_BUF_LO] = chan_a_buffer_code_q;
         end
         `OFS_PDN_CTRL: begin
            rd_mux[`BIT_WHOLE_SLEEP] = whole_sleep_bit_q;
            rd_mux[`BIT_PIN_IGNORE]  = sleep_pin_ignore_q;
            rd_mux[`BIT_PATTERN_SEL] = sleep_pattern_select_q;
         end
         `OFS_INPUT_COUPLING: begin
            rd_mux[`BIT_INPUT_BIAS] = input_bias_bit_q;
         end
         `OFS_SYSREF_CTRL: begin
            rd_mux[`BIT_SYSREF_IGNORE] = sysref_ignore_q;
            rd_mux[`BIT_SYSREF_HCM]    = sysref_hcm_bit_q;
            rd_mux[`BIT_SYSREF_LEVEL]  = sysref_manual_level_q;
         end
         `OFS_SYSREF_MANUAL: begin
            rd_mux[`BIT_SYSREF_MANUAL] = sysref_manual_on_q;
         end
         `OFS_MASK_ENABLE: begin
            rd_mux[`BIT_PATTERN_ENABLE] = sleep_pattern_enable_q;
         end
         default: begin
            rd_mux = `RESET_VALUE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (reset) begin
         rd_data_q  <= `RESET_VALUE;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_en;
         if (rd_en) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power-down combination

   reg [3:0] sel_core;
   reg       sel_a_buf;
   reg       sel_b_buf;
   reg       sleep_now;

   always @* begin
      if (sleep_pattern_select_q) begin
         sel_core  = mask2_core_off;
         sel_a_buf = buf_off(chan_a_buffer_code_q);
         sel_b_buf = buf_off(chan_b_buffer_off_r_q);
      end else begin
         sel_core  = mask1_core_off;
         sel_a_buf = buf_off(mask1_chan_a_buffer_off);
         sel_b_buf = buf_off(mask1_chan_b_buffer_off);
      end
      // pin only counts while override is clear
      sleep_now = whole_sleep_bit_q | (~sleep_pin_ignore_q & pin_level);
   end

   always @(posedge core_clk) begin
      if (reset) begin
         chan_a_core_off_q   <= 4'h0;
         chan_b_core_off_q   <= 4'h0;
         chan_a_buffer_off_q <= 1'b0;
         chan_b_buffer_off_q <= 1'b0;
         whole_device_sleep_q <= 1'b0;
      end else begin
         whole_device_sleep_q <= sleep_now;
         if (sleep_pattern_enable_q) begin
            chan_a_core_off_q   <= {4{sel_core[3]}} & 4'hF;
            chan_b_core_off_q   <= {4{sel_core[0]}} & 4'hF;
            chan_a_buffer_off_q <= sel_a_buf;
            chan_b_buffer_off_q <= sel_b_buf;
         end else begin
            chan_a_core_off_q   <= 4'h0;
            chan_b_core_off_q   <= 4'h0;
            chan_a_buffer_off_q <= 1'b0;
            chan_b_buffer_off_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // analog front end and reference path

   always @(posedge core_clk) begin
      if (reset) begin
         input_bias_high_ohm_q     <= 1'b0;
         sysref_high_common_mode_q <= 1'b0;
         sysref_out_q              <= 1'b0;
      end else begin
         input_bias_high_ohm_q     <= input_bias_bit_q;
         sysref_high_common_mode_q <= sysref_hcm_bit_q;
         if (sysref_manual_on_q) begin
            sysref_out_q <= sysref_manual_level_q;
         end else if (sysref_ignore_q) begin
            sysref_out_q <= 1'b0;
         end else begin
            sysref_out_q <= sysref_level;
         end
      end
   end

endmodule

/* File: hdl/master_page_consts.vh */
// register offsets, field positions and reset values of the master page power/reference slice
`ifndef MASTER_PAGE_CONSTS_VH
`define MASTER_PAGE_CONSTS_VH

`define OFS_MASK1_CORE      8'h20
`define OFS_MASK1_BUF       8'h21
`define OFS_MASK2_CORE      8'h23
`define OFS_MASK2_BUF       8'h24
`define OFS_PDN_CTRL        8'h26
`define OFS_INPUT_COUPLING  8'h4F
`define OFS_SYSREF_CTRL     8'h53
`define OFS_SYSREF_MANUAL   8'h54
`define OFS_MASK_ENABLE     8'h55

`define BIT_CHB_BUF_HI      7
`define BIT_CHB_BUF_LO      6
`define BIT_CHA_BUF_HI      5
`define BIT_CHA_BUF_LO      4
`define BIT_WHOLE_SLEEP     7
`define BIT_PIN_IGNORE      6
`define BIT_PATTERN_SEL     5
`define BIT_INPUT_BIAS      0
`define BIT_SYSREF_IGNORE   6
`define BIT_SYSREF_HCM      1
`define BIT_SYSREF_LEVEL    0
`define BIT_SYSREF_MANUAL   7
`define BIT_PATTERN_ENABLE  4

`define BUF_ALL_ON          2'h0
`define BUF_ALL_OFF         2'h3

`define RESET_VALUE         8'h00

`endif

/* File: hdl/pin_sync3.v */
// three-stage synchroniser for a pin; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
   input  wire core_clk,
   input  wire reset,
   input  wire pin_in,
   output reg  pin_level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge core_clk) begin
      if (reset) begin
         s1_q        <= 1'b0;
         s2_q        <= 1'b0;
         s3_q        <= 1'b0;
         pin_level_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            pin_level_q <= s3_q;
         end
      end
   end
endmodule

/* File: dv/master_page_power_sysref_control_assertions.sv */
// assertions on the power and reference control slice
`timescale 1ns/1ps
module slice_checker (
   input wire       core_clk,
   input wire       reset,
   input wire       wr_en,
   input wire [7:0] addr,
   input wire [7:0] wr_data,
   input wire [3:0] mask1_core_off,
   input wire [1:0] mask1_chan_a_buffer_off,
   input wire [3:0] mask2_core_off,
   input wire [3:0] chan_a_core_off_q,
   input wire [3:0] chan_b_core_off_q,
   input wire       chan_a_buffer_off_q,
   input wire       chan_b_buffer_off_q,
   input wire       whole_device_sleep_q,
   input wire       input_bias_high_ohm_q,
   input wire       sysref_high_common_mode_q,
   input wire       sysref_out_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   reg       en_q, sel_q, ovr_q, slp_q, man_q, ign_q, lvl_q, p2_q;
   reg [1:0] b2_q, p1_q;
   always @(posedge core_clk) begin
      p1_q <= {mask1_core_off[3], |mask1_chan_a_buffer_off};
      p2_q <= mask2_core_off[0];
      if (reset) begin
         {en_q, sel_q, ovr_q, slp_q, man_q, ign_q, lvl_q, b2_q} <= 9'h000;
      end else if (wr_en) begin
         // the sleep bit only sticks when override was stored beforehand
         case (addr)
            8'h24: b2_q <= wr_data[7:6];
            8'h26: {slp_q, ovr_q, sel_q} <= {ovr_q ? wr_data[7] : slp_q, wr_data[6:5]};
            8'h53: {ign_q, lvl_q} <= {wr_data[6], wr_data[0]};
            8'h54: man_q <= wr_data[7];
            8'h55: en_q <= wr_data[4];
            default: ;
         endcase
      end
   end
   a_mask_one_pick: assert property (en_q && !sel_q |=>
      chan_a_core_off_q == {4{p1_q[1]}} && chan_a_buffer_off_q == p1_q[0])
      else $error("mask one not applied");
   a_mask_two_pick: assert property (en_q && sel_q |=>
      chan_b_buffer_off_q == ($past(b2_q) != 2'h0) && chan_b_core_off_q == {4{p2_q}})
      else $error("mask two not applied");
   a_mask_idle_zero: assert property (!en_q |=>
      {chan_a_core_off_q, chan_b_core_off_q, chan_a_buffer_off_q, chan_b_buffer_off_q} == 10'h000)
      else $error("mask outputs active while disabled");
   a_sleep_global: assert property (ovr_q |=> whole_device_sleep_q == $past(slp_q))
      else $error("global sleep wrong");
   a_bias_follow: assert property (wr_en && addr == 8'h4F |-> ##2
      input_bias_high_ohm_q == $past(wr_data[0], 2)) else $error("bias select wrong");
   a_hcm_follow: assert property (wr_en && addr == 8'h53 |-> ##2
      sysref_high_common_mode_q == $past(wr_data[1], 2)) else $error("common mode wrong");
   a_manual_level: assert property (man_q |=> sysref_out_q == $past(lvl_q))
      else $error("manual level wrong");
   a_sysref_ignore: assert property (!man_q && ign_q |=> !sysref_out_q)
      else $error("reference not ignored");
endmodule
bind master_page_power_sysref_control slice_checker chk (.core_clk, .reset, .wr_en, .addr,
   .wr_data, .mask1_core_off, .mask1_chan_a_buffer_off, .mask2_core_off, .chan_a_core_off_q,
   .chan_b_core_off_q, .chan_a_buffer_off_q, .chan_b_buffer_off_q, .whole_device_sleep_q,
   .input_bias_high_ohm_q, .sysref_high_common_mode_q, .sysref_out_q);

/* File: dv/reg_host_model.sv */
// host side of the register port: strobes launched on the falling edge
`timescale 1ns/1ps
module reg_host_model (
   input wire       core_clk,
   input wire [7:0] rd_data_q,
   input wire       rd_valid_q,
   output reg       wr_en,
   output reg       rd_en,
   output reg [7:0] addr,
   output reg [7:0] wr_data
);
   initial {wr_en, rd_en, addr, wr_data} = 18'h00000;
   // callers pass zero reserved bits at mapped offsets and only codes 00 or 11; offset 30 gets FF
   task wr(input [7:0] a, input [7:0] dt);
      begin
         @(negedge core_clk);
         {wr_en, addr, wr_data} = {1'b1, a, dt};
         @(negedge core_clk);
         {wr_en, addr, wr_data} = {1'b0, ~a, ~dt};
      end
   endtask
   task rd(input [7:0] a, output [7:0] dt, output vl);
      begin
         @(negedge core_clk);
         {rd_en, addr} = {1'b1, a};
         @(negedge core_clk);
         {rd_en, addr} = {1'b0, ~a};
         {vl, dt} = {rd_valid_q, rd_data_q};
      end
   endtask
endmodule

/* File: dv/master_page_power_sysref_control_bench.sv */
// self-checking bench of the power and reference control slice
`timescale 1ns/1ps
module master_page_power_sysref_control_bench;
   reg         core_clk = 1'b0;
   reg         reset = 1'b1;
   reg         sleep_pin = 1'b0;
   reg         sysref_in = 1'b0;
   reg  [3:0]  mask1_core_off = 4'h8;
   reg  [1:0]  mask1_chan_a_buffer_off = 2'h3;
   reg  [1:0]  mask1_chan_b_buffer_off = 2'h0;
   reg  [3:0]  mask2_core_off = 4'h1;
   reg  [55:0] ofs = 56'h24264F53545530;
   wire [7:0]  addr, wr_data, rd_data_q;
   wire        wr_en, rd_en, rd_valid_q, chan_a_buffer_off_q, chan_b_buffer_off_q;
   wire [3:0]  chan_a_core_off_q, chan_b_core_off_q;
   wire        whole_device_sleep_q, input_bias_high_ohm_q, sysref_high_common_mode_q;
   wire        sysref_out_q;
   wire [7:0]  cores = {chan_a_core_off_q, chan_b_core_off_q};
   wire [7:0]  flags = {2'h0, chan_a_buffer_off_q, chan_b_buffer_off_q, whole_device_sleep_q,
                        input_bias_high_ohm_q, sysref_high_common_mode_q, sysref_out_q};
   integer     n_errors = 0;
   integer     n_tests = 0;
   integer     i;
   reg  [7:0]  d;
   reg         v;
   always #5 core_clk = ~core_clk;
   master_page_power_sysref_control dut (.core_clk, .reset, .wr_en, .rd_en, .addr, .wr_data,
      .rd_data_q, .rd_valid_q, .sleep_pin, .sysref_in, .mask1_core_off,
      .mask1_chan_a_buffer_off, .mask1_chan_b_buffer_off, .mask2_core_off, .chan_a_core_off_q,
      .chan_b_core_off_q, .chan_a_buffer_off_q, .chan_b_buffer_off_q, .whole_device_sleep_q,
      .input_bias_high_ohm_q, .sysref_high_common_mode_q, .sysref_out_q);
   reg_host_model host (.core_clk, .rd_data_q, .rd_valid_q, .wr_en, .rd_en, .addr, .wr_data);
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task rchk(input [7:0] a, input [7:0] e);
      begin
         host.rd(a, d, v);
         chk({7'h00, v}, 8'h01);
         chk(d, e);
      end
   endtask
   task wt(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   task results;
      begin
         if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   task t_zero;
      begin
         chk(cores, 8'h00);
         chk(flags, 8'h00);
         for (i = 0; i < 7; i = i + 1) begin
            rchk(ofs[8*i +: 8], 8'h00);
         end
      end
   endtask
   task t_sleep;
      begin
         host.wr(8'h26, 8'hC0);
         rchk(8'h26, 8'h40);
         host.wr(8'h26, 8'hC0);
         rchk(8'h26, 8'hC0);
         chk(flags, 8'h08);
         host.wr(8'h26, 8'h80);
         // a refused write keeps the stored sleep bit
         host.wr(8'h26, 8'h00);
         rchk(8'h26, 8'h80);
         host.wr(8'h26, 8'h40);
         sleep_pin = 1'b1;
         host.wr(8'h26, 8'h40);
         wt(8);
         chk(flags, 8'h00);
         host.wr(8'h26, 8'h00);
         wt(8);
         chk(flags, 8'h08);
         sleep_pin = 1'b0;
         wt(8);
      end
   endtask
   task t_masks;
      begin
         host.wr(8'h24, 8'hC0);
         rchk(8'h24, 8'hC0);
         chk(cores, 8'h00);
         host.wr(8'h55, 8'h10);
         rchk(8'h55, 8'h10);
         chk(cores, 8'hF0);
         chk(flags, 8'h20);
         mask1_core_off = 4'h9;
         mask1_chan_b_buffer_off = 2'h3;
         wt(2);
         chk(cores, 8'hFF);
         chk(flags, 8'h30);
         host.wr(8'h26, 8'h20);
         wt(2);
         chk(cores, 8'h0F);
         chk(flags, 8'h10);
         host.wr(8'h24, 8'h00);
         wt(2);
         chk(flags, 8'h00);
         host.wr(8'h55, 8'h00);
         host.wr(8'h26, 8'h00);
         wt(2);
         chk(cores, 8'h00);
      end
   endtask
   task t_sysref;
      begin
         host.wr(8'h4F, 8'h01);
         host.wr(8'h53, 8'h02);
         wt(2);
         chk(flags, 8'h06);
         sysref_in = 1'b1;
         wt(8);
         chk(flags, 8'h07);
         host.wr(8'h53, 8'h42);
         wt(2);
         chk(flags, 8'h06);
         host.wr(8'h54, 8'h80);
         host.wr(8'h53, 8'h43);
         wt(2);
         chk(flags, 8'h07);
         host.wr(8'h53, 8'h42);
         wt(2);
         chk(flags, 8'h06);
         sysref_in = 1'b0;
         host.wr(8'h30, 8'hFF);
         rchk(8'h30, 8'h00);
      end
   endtask
   initial begin
      #200000;
      n_errors = n_errors + 1;
      results;
   end
   initial begin
      wt(4);
      reset = 1'b0;
      t_zero;
      t_sleep;
      t_masks;
      t_sysref;
      reset = 1'b1;
      wt(4);
      reset = 1'b0;
      t_zero;
      results;
   end
endmodule
